// ### pkg/backlight_cfg_pkg.sv
/*
 * Constants, field layouts and carrier types of the backlight configuration bank.
 * Assumes a single 50 MHz system clock shared by every user of the package.
 */
package backlight_cfg_pkg;

   // Register addresses on the plain register port
   localparam logic [7:0] ADDR_RAMP_CFG = 8'hA1;
   localparam logic [7:0] ADDR_BOOST_CFG = 8'hA2;
   localparam logic [7:0] ADDR_LOCKOUT_CFG = 8'hA3;

   // Values after reset, equal to the factory nonvolatile image
   localparam logic [7:0] RST_RAMP_CFG = 8'hF5;
   localparam logic [7:0] RST_BOOST_CFG = 8'hBF;
   localparam logic [7:0] RST_LOCKOUT_CFG = 8'h7B;

   // Field positions, first register
   localparam int SWRATE_LSB = 6;
   localparam int DIM_MODE_BIT = 5;
   localparam int THERM_LSB = 3;
   localparam int RAMP_LSB = 0;
   // Field positions, second register
   localparam int ADAPT_SPEED_LSB = 6;
   localparam int SMOOTH_BIT = 5;
   localparam int SPLIT_BIT = 4;
   localparam int ADAPT_BIT = 3;
   localparam int BOOST_EN_BIT = 2;
   localparam int IMAX_BIT = 1;
   // Field positions, third register
   localparam int LOCKOUT_LSB = 6;
   localparam int STAGGER_BIT = 5;
   localparam int PWMRATE_LSB = 0;

   // Derating thresholds in degrees Celsius
   localparam logic [7:0] THERM_LOW_C = 8'd110;
   localparam logic [7:0] THERM_MID_C = 8'd120;
   localparam logic [7:0] THERM_HIGH_C = 8'd130;

   // Crossover levels of automatic dimming, full scale, and the highest adaptive boost code
   localparam logic [7:0] SPLIT_HALF = 8'h80;
   localparam logic [7:0] SPLIT_QUARTER = 8'h40;
   localparam logic [7:0] FULL_LEVEL = 8'hFF;
   localparam logic [4:0] BOOST_CODE_MAX = 5'h1E;

   // Ramp times in milliseconds, cycle count per millisecond
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int RAMP_ACC_W = 26;

   function automatic logic [9:0] rampMs(input logic [2:0] code);
      case (code)
         3'h1: rampMs = 10'd50;
         3'h2: rampMs = 10'd75;
         3'h3: rampMs = 10'd100;
         3'h4: rampMs = 10'd150;
         3'h5: rampMs = 10'd200;
         3'h6: rampMs = 10'd300;
         3'h7: rampMs = 10'd500;
         default: rampMs = 10'd0;
      endcase
   endfunction

   typedef struct packed {
      logic [7:0] lockout;
      logic [7:0] boost;
      logic [7:0] ramp;
   } cfg_regs_t;

   typedef struct packed {
      logic [7:0] pwmDuty;
      logic [7:0] currentLevel;
   } dim_out_t;

   typedef struct packed {
      logic [1:0] converterSwitchRate;
      logic [1:0] adaptiveSpeed;
      logic smoothRampBit;
      logic boostEnable;
      logic inductorCurrentLimitBit;
      logic [1:0] lowSupplyLockoutField;
      logic staggeredPwmEnable;
      logic [4:0] pwmRateField;
   } cfg_out_t;

   typedef enum logic [1:0] {
      BOOST_OFF = 2'b00,
      BOOST_FIXED = 2'b01,
      BOOST_ADAPT = 2'b10
   } boost_state_t;

endpackage

// ### rtl/backlight_config_bank.sv
/*
 * Backlight configuration bank: three 8-bit settings registers with their
 * dimming split, thermal derating, brightness ramp and boost voltage control.
 * Assumes one 50 MHz clock; brightness, temperature, headroom and nonvolatile
 * load inputs come from logic on the same clock.
 */
// The implementer's own choice: strobed register access.
// Summary of operation
// - With the dimming-mode bit clear, brightness is PWM duty only at constant current.
// - With the dimming-mode bit set, PWM and current dimming are chosen automatically.
// - The thermal field selects derating at 110, 120 or 130 degrees for codes 01, 10, 11.
// - A thermal field of 00 turns derating off entirely.
// - A ramp field of 000 applies a new brightness at once.
// - Other ramp codes spread each change over 50, 75, 100, 150, 200, 300 or 500 ms.
// - The split bit picks the 50 percent crossover when 0 and 25 percent when 1.
// - With adaptive boost off, the boost voltage follows the setpoint directly.
// - The current limit bit selects 1.4 A when 0 and 2.5 A when 1.
// - With adaptive boost on, the setpoint is only the start voltage, adapted afterwards.
`timescale 1ns/100ps
module backlight_config_bank #(
   parameter int TICK_CYCLES = backlight_cfg_pkg::MS_CYCLES,
   parameter int LEVEL_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] wrData,
   input wire logic wrStrobe,
   input wire logic rdStrobe,
   output logic [7:0] rdData,
   input wire logic nvLoad,
   input wire logic [7:0] nvAddr,
   input wire logic [7:0] nvData,
   input wire logic [LEVEL_W-1:0] brightness,
   input wire logic [7:0] dieTemp,
   input wire logic backlightOn,
   input wire logic [4:0] boostVoltageSetpoint,
   input wire logic headroomLow,
   input wire logic headroomHigh,
   output backlight_cfg_pkg::dim_out_t dimOut,
   output logic derateActive,
   output logic rampBusy,
   output logic [4:0] boostVoltageCode,
   output backlight_cfg_pkg::boost_state_t boostState,
   output backlight_cfg_pkg::cfg_out_t cfgOut
);

   typedef struct packed {
      backlight_cfg_pkg::cfg_regs_t regs;
      logic [7:0] rdData;
      logic derate;
      backlight_cfg_pkg::dim_out_t dim;
      backlight_cfg_pkg::boost_state_t boost;
      logic [4:0] boostCode;
   } bank_state_t;

   bank_state_t state;
   bank_state_t next_state;
   logic [LEVEL_W-1:0] rampLevel;
   logic [LEVEL_W-1:0] rampTarget;
   logic [backlight_cfg_pkg::RAMP_ACC_W-1:0] rampCycles;

   // Field views of the registers
   logic dimMode;
   logic splitQuarter;
   logic adaptOn;
   logic boostOn;
   logic [1:0] thermField;
   logic [2:0] rampField;

   assign dimMode = state.regs.ramp[backlight_cfg_pkg::DIM_MODE_BIT];
   assign thermField = state.regs.ramp[backlight_cfg_pkg::THERM_LSB +: 2];
   assign rampField = state.regs.ramp[backlight_cfg_pkg::RAMP_LSB +: 3];
   assign splitQuarter = state.regs.boost[backlight_cfg_pkg::SPLIT_BIT];
   assign adaptOn = state.regs.boost[backlight_cfg_pkg::ADAPT_BIT];
   assign boostOn = state.regs.boost[backlight_cfg_pkg::BOOST_EN_BIT];

   function automatic logic [7:0] regValue(input backlight_cfg_pkg::cfg_regs_t regs,
                                           input logic [7:0] addr);
      case (addr)
         backlight_cfg_pkg::ADDR_RAMP_CFG: regValue = regs.ramp;
         backlight_cfg_pkg::ADDR_BOOST_CFG: regValue = regs.boost;
         backlight_cfg_pkg::ADDR_LOCKOUT_CFG: regValue = regs.lockout;
         default: regValue = 8'h00;
      endcase
   endfunction

   function automatic backlight_cfg_pkg::cfg_regs_t regStore(
         input backlight_cfg_pkg::cfg_regs_t regs,
         input logic [7:0] addr,
         input logic [7:0] data);
      regStore = regs;
      case (addr)
         backlight_cfg_pkg::ADDR_RAMP_CFG: regStore.ramp = data;
         backlight_cfg_pkg::ADDR_BOOST_CFG: regStore.boost = data;
         backlight_cfg_pkg::ADDR_LOCKOUT_CFG: regStore.lockout = data;
         default: regStore = regs;
      endcase
   endfunction

   // Temperature at which derating starts; zero means never
   function automatic logic [7:0] thermLimit(input logic [1:0] field);
      case (field)
         2'b01: thermLimit = backlight_cfg_pkg::THERM_LOW_C;
         2'b10: thermLimit = backlight_cfg_pkg::THERM_MID_C;
         2'b11: thermLimit = backlight_cfg_pkg::THERM_HIGH_C;
         default: thermLimit = 8'h00;
      endcase
   endfunction

   // Split one brightness level into PWM duty and LED current
   function automatic backlight_cfg_pkg::dim_out_t dimSplit(input logic auto,
                                                             input logic quarter,
                                                             input logic [7:0] lvl);
      logic [7:0] crossLvl;
      crossLvl = quarter ? backlight_cfg_pkg::SPLIT_QUARTER : backlight_cfg_pkg::SPLIT_HALF;
      if (!auto) begin
         // Constant current, duty carries brightness
         dimSplit.currentLevel = backlight_cfg_pkg::FULL_LEVEL;
         dimSplit.pwmDuty = lvl;
      end else if (lvl >= crossLvl) begin
         // Upper range: full duty, current carries brightness
         dimSplit.currentLevel = lvl;
         dimSplit.pwmDuty = backlight_cfg_pkg::FULL_LEVEL;
      end else begin
         // Lower range: current parked at crossover, duty scaled
         dimSplit.currentLevel = crossLvl;
         dimSplit.pwmDuty = quarter ? {lvl[5:0], 2'b00} : {lvl[6:0], 1'b0};
      end
   endfunction

   // Halved target while hot keeps the die from running away
   assign rampTarget = state.derate ? LEVEL_W'(brightness >> 1)
                                    : brightness;
   assign rampCycles = backlight_cfg_pkg::RAMP_ACC_W'(
      backlight_cfg_pkg::RAMP_ACC_W'(backlight_cfg_pkg::rampMs(rampField))
      * backlight_cfg_pkg::RAMP_ACC_W'(TICK_CYCLES));

   brightness_ramp #(
      .WIDTH(LEVEL_W),
      .ACC_W(backlight_cfg_pkg::RAMP_ACC_W)
   ) u_ramp (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .target(rampTarget),
      .rampCycles(rampCycles),
      .level(rampLevel),
      .busy(rampBusy)
   );

   always_comb begin
      next_state = state;
      // Nonvolatile load first, so a same-cycle bus write has the last word
      if (nvLoad) begin
         next_state.regs = regStore(next_state.regs, nvAddr, nvData);
      end
      if (wrStrobe) begin
         next_state.regs = regStore(next_state.regs, regAddr, wrData);
      end
      next_state.rdData = rdStrobe ? regValue(state.regs, regAddr) : 8'h00;

      // Derating only with a non-zero threshold
      next_state.derate = (thermField != 2'b00) && (dieTemp >= thermLimit(thermField));

      next_state.dim = dimSplit(dimMode, splitQuarter, 8'(rampLevel));

      case (state.boost)
         backlight_cfg_pkg::BOOST_OFF: begin
            if (boostOn && backlightOn) begin
               // Start voltage always comes from the setpoint
               next_state.boostCode = boostVoltageSetpoint;
               next_state.boost = adaptOn ? backlight_cfg_pkg::BOOST_ADAPT
                                          : backlight_cfg_pkg::BOOST_FIXED;
            end
         end
         backlight_cfg_pkg::BOOST_FIXED: begin
            next_state.boostCode = boostVoltageSetpoint;
            if (!boostOn || !backlightOn) begin
               next_state.boost = backlight_cfg_pkg::BOOST_OFF;
            end else if (adaptOn) begin
               next_state.boost = backlight_cfg_pkg::BOOST_ADAPT;
            end
         end
         backlight_cfg_pkg::BOOST_ADAPT: begin
            // Headroom feedback trims the voltage after start
            if (headroomLow && state.boostCode < backlight_cfg_pkg::BOOST_CODE_MAX) begin
               next_state.boostCode = state.boostCode + 5'h01;
            end else if (headroomHigh && !headroomLow && state.boostCode != 5'h00) begin
               next_state.boostCode = state.boostCode - 5'h01;
            end
            if (!boostOn || !backlightOn) begin
               next_state.boost = backlight_cfg_pkg::BOOST_OFF;
            end else if (!adaptOn) begin
               next_state.boost = backlight_cfg_pkg::BOOST_FIXED;
               next_state.boostCode = boostVoltageSetpoint;
            end
         end
         default: begin
            next_state.boost = backlight_cfg_pkg::BOOST_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state.regs.ramp <= backlight_cfg_pkg::RST_RAMP_CFG;
         state.regs.boost <= backlight_cfg_pkg::RST_BOOST_CFG;
         state.regs.lockout <= backlight_cfg_pkg::RST_LOCKOUT_CFG;
         state.rdData <= 8'h00;
         state.derate <= 1'b0;
         state.dim <= '0;
         state.boost <= backlight_cfg_pkg::BOOST_OFF;
         state.boostCode <= 5'h00;
      end else begin
         state <= next_state;
      end
   end

   assign rdData = state.rdData;
   assign dimOut = state.dim;
   assign derateActive = state.derate;
   assign boostVoltageCode = state.boostCode;
   assign boostState = state.boost;

   always_comb begin
      cfgOut.converterSwitchRate = state.regs.ramp[backlight_cfg_pkg::SWRATE_LSB +: 2];
      cfgOut.adaptiveSpeed = state.regs.boost[backlight_cfg_pkg::ADAPT_SPEED_LSB +: 2];
      cfgOut.smoothRampBit = state.regs.boost[backlight_cfg_pkg::SMOOTH_BIT];
      cfgOut.boostEnable = boostOn;
      cfgOut.inductorCurrentLimitBit = state.regs.boost[backlight_cfg_pkg::IMAX_BIT];
      cfgOut.lowSupplyLockoutField = state.regs.lockout[backlight_cfg_pkg::LOCKOUT_LSB +: 2];
      cfgOut.staggeredPwmEnable = state.regs.lockout[backlight_cfg_pkg::STAGGER_BIT];
      cfgOut.pwmRateField = state.regs.lockout[backlight_cfg_pkg::PWMRATE_LSB +: 5];
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_readback_full_byte: assert property (
      wrStrobe && regAddr == backlight_cfg_pkg::ADDR_LOCKOUT_CFG
      ##1 rdStrobe && !wrStrobe && !nvLoad && regAddr == backlight_cfg_pkg::ADDR_LOCKOUT_CFG
      |=> rdData == $past(wrData, 2))
      else $error("read did not return the written byte");

   a_pwm_only_mode: assert property (
      !dimMode |=> dimOut.currentLevel == backlight_cfg_pkg::FULL_LEVEL
                   && dimOut.pwmDuty == 8'($past(rampLevel)))
      else $error("constant current mode altered the current");

   a_auto_upper_range: assert property (
      dimMode && 8'(rampLevel) >= backlight_cfg_pkg::SPLIT_HALF
      |=> dimOut.pwmDuty == backlight_cfg_pkg::FULL_LEVEL
          && dimOut.currentLevel == 8'($past(rampLevel)))
      else $error("automatic mode did not use current dimming");

   a_split_crossover: assert property (
      dimMode && 8'(rampLevel) < backlight_cfg_pkg::SPLIT_QUARTER
      |=> dimOut.currentLevel == ($past(splitQuarter) ? backlight_cfg_pkg::SPLIT_QUARTER
                                                     : backlight_cfg_pkg::SPLIT_HALF))
      else $error("crossover level does not match split bit");

   a_derate_threshold: assert property (
      thermField == 2'b10 && dieTemp == 8'd119 ##1 thermField == 2'b10 && dieTemp == 8'd120
      |-> !derateActive ##1 derateActive)
      else $error("derating did not start at the selected temperature");

   a_derate_disabled: assert property (
      thermField == 2'b00 |=> !derateActive)
      else $error("derating active with threshold disabled");

   a_ramp_immediate: assert property (
      rampField == 3'b000 |=> rampLevel == $past(rampTarget))
      else $error("brightness not applied at once");

   a_ramp_gradual: assert property (
      rampField != 3'b000 && $stable(rampField) && rampTarget != rampLevel
      && $past(rampTarget) != $past(rampLevel) && $stable(rampTarget)
      |=> rampLevel != $past(rampTarget) || $past(rampLevel) + 1'b1 == $past(rampTarget)
          || $past(rampLevel) - 1'b1 == $past(rampTarget))
      else $error("ramp jumped to target");

   a_boost_direct: assert property (
      boostState == backlight_cfg_pkg::BOOST_FIXED && !adaptOn && boostOn && backlightOn
      |=> boostVoltageCode == $past(boostVoltageSetpoint))
      else $error("fixed boost did not follow setpoint");

   a_current_limit: assert property (
      wrStrobe && regAddr == backlight_cfg_pkg::ADDR_BOOST_CFG
      |=> cfgOut.inductorCurrentLimitBit == $past(wrData[1]))
      else $error("current limit does not follow written bit");

   a_adapt_start: assert property (
      boostState == backlight_cfg_pkg::BOOST_OFF && boostOn && backlightOn && adaptOn
      |=> boostState == backlight_cfg_pkg::BOOST_ADAPT
          && boostVoltageCode == $past(boostVoltageSetpoint))
      else $error("adaptive boost did not start at setpoint");

   a_adapt_trims: assert property (
      boostState == backlight_cfg_pkg::BOOST_ADAPT && adaptOn && boostOn && backlightOn
      && headroomLow && boostVoltageCode < backlight_cfg_pkg::BOOST_CODE_MAX
      |=> boostVoltageCode == $past(boostVoltageCode) + 5'h01)
      else $error("adaptive boost did not raise the voltage");

endmodule

// ### rtl/brightness_ramp.sv
/*
 * Spreads every brightness change evenly over a programmable number of cycles.
 * Assumes target and ramp length come from logic on the same clock.
 */
`timescale 1ns/100ps
module brightness_ramp #(
   parameter int WIDTH = 8,
   parameter int ACC_W = backlight_cfg_pkg::RAMP_ACC_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] target,
   input wire logic [ACC_W-1:0] rampCycles,
   output logic [WIDTH-1:0] level,
   output logic busy
);

   typedef struct packed {
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] lastTarget;
      logic [WIDTH-1:0] span;
      logic [ACC_W:0] acc;
   } ramp_state_t;

   ramp_state_t state;
   ramp_state_t next_state;

   function automatic logic [WIDTH-1:0] absDiff(input logic [WIDTH-1:0] a,
                                                input logic [WIDTH-1:0] b);
      absDiff = (a > b) ? a - b : b - a;
   endfunction

   always_comb begin
      logic [ACC_W:0] sum;
      sum = '0;
      next_state = state;
      if (rampCycles == '0) begin
         // Zero length: jump straight to the new value
         next_state.level = target;
         next_state.lastTarget = target;
         next_state.span = '0;
         next_state.acc = '0;
      end else if (target != state.lastTarget) begin
         // Span latched once so the whole change takes the full time
         next_state.lastTarget = target;
         next_state.span = absDiff(target, state.level);
         next_state.acc = '0;
      end else if (state.level != target) begin
         // Bresenham: span steps spread over rampCycles cycles
         // One level per cycle at most, so rampCycles below span stretches it
         sum = state.acc + (ACC_W+1)'(state.span);
         if (sum >= (ACC_W+1)'(rampCycles)) begin
            next_state.acc = sum - (ACC_W+1)'(rampCycles);
            next_state.level = (target > state.level) ? state.level + 1'b1
                                                      : state.level - 1'b1;
         end else begin
            next_state.acc = sum;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign level = state.level;
   assign busy = (state.level != state.lastTarget);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_ramp_single_step: assert property (
      rampCycles != '0 && $past(rampCycles) != '0
      |-> absDiff(level, $past(level)) <= WIDTH'(1))
      else $error("ramp moved more than one level in a cycle");

   a_ramp_zero_jump: assert property (
      rampCycles == '0 |=> level == $past(target))
      else $error("zero ramp did not apply target at once");

endmodule

// ### tb/backlight_config_bank_tb_top.sv
/*
 * Self-checking bench of the backlight configuration bank: register port,
 * nonvolatile load, dimming split, derating, ramp timing and boost control.
 * Assumes the package is compiled first and the design runs with a short tick.
 */
`timescale 1ns/100ps
module backlight_config_bank_tb_top;
   // Shortest ramp must still last 255 cycles, one level per cycle
   localparam int TICK = 6;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] regAddr = 8'h00, wrData = 8'h00, nvAddr = 8'h00, nvData = 8'h00;
   logic wrStrobe = 1'b0, rdStrobe = 1'b0, nvLoad = 1'b0, backlightOn = 1'b0;
   logic [7:0] brightness = 8'h00, dieTemp = 8'h19;
   logic [4:0] boostVoltageSetpoint = 5'h0C;
   logic headroomLow = 1'b0, headroomHigh = 1'b0;
   logic [7:0] rdData;
   logic derateActive, rampBusy;
   logic [4:0] boostVoltageCode;
   backlight_cfg_pkg::dim_out_t dimOut;
   backlight_cfg_pkg::boost_state_t boostState;
   backlight_cfg_pkg::cfg_out_t cfgOut;
   int errors = 0;
   int checks_done = 0;

   always #10 sys_clk = ~sys_clk;

   backlight_config_bank #(.TICK_CYCLES(TICK)) backlight_config_bank_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .nvLoad(nvLoad),
      .nvAddr(nvAddr), .nvData(nvData), .brightness(brightness), .dieTemp(dieTemp),
      .backlightOn(backlightOn), .boostVoltageSetpoint(boostVoltageSetpoint),
      .headroomLow(headroomLow), .headroomHigh(headroomHigh), .dimOut(dimOut),
      .derateActive(derateActive), .rampBusy(rampBusy),
      .boostVoltageCode(boostVoltageCode), .boostState(boostState), .cfgOut(cfgOut));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wrStrobe <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge sys_clk);
      wrStrobe <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      rdStrobe <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      rdStrobe <= 1'b0;
      #1 chk(rdData, exp, "read data");
   endtask

   // Write, then read back in the very next cycle
   task automatic wrRd(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wrStrobe <= 1'b1;
      regAddr <= a;
      wrData <= d;
      @(posedge sys_clk);
      wrStrobe <= 1'b0;
      rdStrobe <= 1'b1;
      @(posedge sys_clk);
      rdStrobe <= 1'b0;
      #1 chk(rdData, d, "write then read");
   endtask

   // Ends mid-cycle, so outputs are settled; drive again only after an edge
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   // Rows: ramp reg, boost reg, brightness, expected duty, expected current
   logic [39:0] dimRows [5] = '{40'h00_06_40_40_FF, 40'h20_06_40_80_80, 40'h20_06_C0_FF_C0,
                                40'h20_16_20_80_40, 40'h20_16_60_FF_60};
   int rampMsTab [7] = '{50, 75, 100, 150, 200, 300, 500};
   logic [7:0] thrTab [4] = '{8'h00, 8'd110, 8'd120, 8'd130};

   initial begin
      #400000;
      errors++;
      $display("wrong value at %0t ns: watchdog expired", $time);
      stop_test();
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(backlight_cfg_pkg::ADDR_RAMP_CFG, backlight_cfg_pkg::RST_RAMP_CFG);
      rd(backlight_cfg_pkg::ADDR_BOOST_CFG, backlight_cfg_pkg::RST_BOOST_CFG);
      rd(backlight_cfg_pkg::ADDR_LOCKOUT_CFG, backlight_cfg_pkg::RST_LOCKOUT_CFG);
      chk(cfgOut, {backlight_cfg_pkg::RST_RAMP_CFG[7:6], backlight_cfg_pkg::RST_BOOST_CFG[7:5],
          backlight_cfg_pkg::RST_BOOST_CFG[2:1], backlight_cfg_pkg::RST_LOCKOUT_CFG},
          "reset fields");
      rd(8'hA4, 8'h00);
      wr(8'hA4, 8'hFF);
      wr(8'hA1, 8'h5A);
      wr(8'hA2, 8'h05);
      wrRd(8'hA3, 8'hA9);
      rd(8'hA1, 8'h5A);
      rd(8'hA2, 8'h05);
      rd(8'hA3, 8'hA9);
      chk(cfgOut.inductorCurrentLimitBit, 1'b0, "current limit low");
      chk({cfgOut.lowSupplyLockoutField, cfgOut.staggeredPwmEnable, cfgOut.pwmRateField},
          8'hA9, "lockout fields");
      wr(8'hA2, 8'h02);
      #1 chk(cfgOut.inductorCurrentLimitBit, 1'b1, "current limit high");
      @(posedge sys_clk);
      nvLoad <= 1'b1;
      nvAddr <= 8'hA3;
      nvData <= 8'h55;
      @(posedge sys_clk);
      nvLoad <= 1'b0;
      rd(8'hA3, 8'h55);
      // Dimming with immediate brightness steps
      foreach (dimRows[i]) begin
         wr(8'hA1, dimRows[i][39:32]);
         wr(8'hA2, dimRows[i][31:24]);
         brightness <= dimRows[i][23:16];
         settle(4);
         chk(dimOut, dimRows[i][15:0], "dim split");
      end
      // Derating threshold per code, code 00 never derates even when hot
      for (int c = 0; c < 4; c++) begin
         wr(8'hA1, 8'(c << 3));
         dieTemp <= (c == 0) ? 8'hFF : thrTab[c] - 8'd1;
         settle(3);
         chk(derateActive, 1'b0, "below threshold");
         if (c != 0) begin
            @(posedge sys_clk);
            dieTemp <= thrTab[c];
            settle(3);
            chk(derateActive, 1'b1, "at threshold");
         end
      end
      @(posedge sys_clk);
      brightness <= 8'h80;
      settle(4);
      chk(dimOut, 16'h40FF, "derated level");
      @(posedge sys_clk);
      dieTemp <= 8'h19;
      // Ramp spans, shortened by the small tick
      for (int c = 1; c < 8; c++) begin
         wr(8'hA1, 8'h00);
         brightness <= 8'h00;
         settle(4);
         chk(dimOut.pwmDuty, 8'h00, "immediate level");
         wr(8'hA1, 8'(c));
         brightness <= 8'hFF;
         settle(10);
         chk(rampBusy, 1'b1, "ramp started");
         settle(rampMsTab[c - 1] * TICK - 30);
         chk(rampBusy, 1'b1, "ramp still running");
         settle(40);
         chk(rampBusy, 1'b0, "ramp finished");
         chk(dimOut.pwmDuty, 8'hFF, "ramp end level");
      end
      // Boost in fixed mode follows the setpoint and ignores headroom
      wr(8'hA2, 8'h06);
      backlightOn <= 1'b1;
      settle(3);
      chk({boostState, boostVoltageCode}, {2'b01, 5'h0C}, "fixed start");
      @(posedge sys_clk);
      boostVoltageSetpoint <= 5'h0D;
      headroomLow <= 1'b1;
      settle(3);
      chk(boostVoltageCode, 5'h0D, "fixed follows setpoint");
      @(posedge sys_clk);
      headroomLow <= 1'b0;
      backlightOn <= 1'b0;
      settle(2);
      chk(boostState, 2'b00, "fixed boost off");
      // Adaptive mode starts at the setpoint, then trims on headroom
      wr(8'hA2, 8'h0E);
      backlightOn <= 1'b1;
      settle(2);
      chk({boostState, boostVoltageCode}, {2'b10, 5'h0D}, "adaptive start");
      @(posedge sys_clk);
      headroomLow <= 1'b1;
      repeat (3) @(posedge sys_clk);
      headroomLow <= 1'b0;
      headroomHigh <= 1'b1;
      @(posedge sys_clk);
      headroomHigh <= 1'b0;
      boostVoltageSetpoint <= 5'h02;
      settle(3);
      chk(boostVoltageCode, 5'h0F, "adaptive trims");
      @(posedge sys_clk);
      headroomLow <= 1'b1;
      repeat (25) @(posedge sys_clk);
      headroomLow <= 1'b0;
      settle(2);
      chk(boostVoltageCode, 5'h1E, "adaptive cap");
      @(posedge sys_clk);
      backlightOn <= 1'b0;
      settle(2);
      chk(boostState, 2'b00, "adaptive boost off");
      stop_test();
   end
endmodule
